// ==== rtl/pgr_pkg.sv ====
/*
  Constants and types for the unlock key, regulator status and power-good control registers.
  Assumes an I2C front end that turns each bus transaction into register strobes.
*/
// Contract
// - The unlock key returns to zero once the transaction after the key write completes.
// - Key 0111_1101 allows exactly one protected write, which the host issues next.
// - Every other key value, zero and all-ones included, blocks protected writes.
// - The power-good control and buck A control registers ignore writes without the key.
// - Buck A, B and C status at bits 4, 3, 2 read 1 only while in regulation.
// - Linear regulator C status at bit 6 reads 1 when in regulation or a load switch.
// - Linear regulator D status at bit 5 reads 1 when in regulation or a load switch.
// - Linear regulator A and B status at bits 1, 0 read 1 only while in regulation.
// - Mask bit 3 clear lets a low regulator A status pull the pin low; reset is set.
// - Mask bit 2 clear lets a low regulator B status pull the pin low; reset is set.
// - Delay code 00/01/10/11 gives 20/100/200/400 ms before the pin rises; reset 00.
// - External adjust 0 makes the buck follow the code, 1 makes the code ignored.
package pgr_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_UNLOCK_KEY = 8'h0B;
  localparam logic [7:0] OFF_GOOD_STATUS = 8'h0C;
  localparam logic [7:0] OFF_GOOD_PIN_CTRL = 8'h0D;
  localparam logic [7:0] OFF_BUCK_A_CTRL = 8'h0E;

  // ----------------------------------------------------------------
  // Values and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] UNLOCK_CODE = 8'h7D;
  localparam logic [7:0] KEY_RESET = 8'h00;
  localparam logic [7:0] PIN_CTRL_RESET = 8'h0C;
  localparam logic [7:0] PIN_CTRL_WMASK = 8'h0F;
  localparam logic [7:0] BUCK_A_WMASK = 8'hBF;
  localparam logic [7:0] BUCK_A_RESET = 8'h1E;
  localparam int MASK_A_BIT = 3;
  localparam int MASK_B_BIT = 2;
  localparam int EXT_ADJ_BIT = 7;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int DLY0_MS = 20;
  localparam int DLY1_MS = 100;
  localparam int DLY2_MS = 200;
  localparam int DLY3_MS = 400;
  localparam int DLY0_CYC = DLY0_MS * 1000 * CLK_MHZ;
  localparam int DLY1_CYC = DLY1_MS * 1000 * CLK_MHZ;
  localparam int DLY2_CYC = DLY2_MS * 1000 * CLK_MHZ;
  localparam int DLY3_CYC = DLY3_MS * 1000 * CLK_MHZ;
  localparam int DLY_W = 27;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] data;
  } pgr_req_t;

  typedef enum logic [1:0] {
    KEY_IDLE = 2'b00,
    KEY_WRITTEN = 2'b01,
    KEY_LIVE = 2'b10
  } pgr_key_st_t;

endpackage

// ==== rtl/pgr_regs.sv ====
/*
  Unlock key, regulator status, power-good pin control and buck A control registers.
  Assumes the I2C engine gives one-cycle strobes on this clock and marks each stop with txnDone.
*/
`timescale 1ns/100ps
module pgr_regs
  import pgr_pkg::*;
#(
  parameter int DLY0_CYCLES = DLY0_CYC,
  parameter int DLY1_CYCLES = DLY1_CYC,
  parameter int DLY2_CYCLES = DLY2_CYC,
  parameter int DLY3_CYCLES = DLY3_CYC,
  parameter logic [7:0] BUCK_A_RESET_CODE = BUCK_A_RESET
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic ce,
  input wire pgr_req_t req,
  input wire logic txnDone,
  output logic [7:0] rdData,
  input wire logic [2:0] buckInReg,
  input wire logic [3:0] linregInReg,
  input wire logic loadSwitchA,
  input wire logic loadSwitchB,
  output logic powerGoodOut,
  output logic powerGoodOeN,
  output logic buckAExternalAdjust,
  output logic [5:0] buckAVoltageCode
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Register select for one offset
  function automatic logic addrHit(input logic [7:0] addr, input logic [7:0] off);
    addrHit = (addr == off);
  endfunction

  // Cycle count for a delay code
  function automatic logic [DLY_W-1:0] delayCycles(input logic [1:0] code);
    case (code)
      2'b00: delayCycles = DLY_W'(DLY0_CYCLES);
      2'b01: delayCycles = DLY_W'(DLY1_CYCLES);
      2'b10: delayCycles = DLY_W'(DLY2_CYCLES);
      default: delayCycles = DLY_W'(DLY3_CYCLES);
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Status synchronisers
  // ----------------------------------------------------------------
  wire logic [8:0] rawStatus = {loadSwitchB, loadSwitchA, linregInReg, buckInReg};
  logic [8:0] statMeta_ff;
  logic [8:0] statSync_ff;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      statMeta_ff <= '0;
    end else if (ce) begin
      statMeta_ff <= rawStatus;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      statSync_ff <= '0;
    end else if (ce) begin
      statSync_ff <= statMeta_ff;
    end
  end

  wire logic buckAGood = statSync_ff[0];
  wire logic buckBGood = statSync_ff[1];
  wire logic buckCGood = statSync_ff[2];
  wire logic linregAGood = statSync_ff[3];
  wire logic linregBGood = statSync_ff[4];
  wire logic linregCGood = statSync_ff[5];
  wire logic linregDGood = statSync_ff[6];
  wire logic loadSwitchAOn = statSync_ff[7];
  wire logic loadSwitchBOn = statSync_ff[8];

  wire logic [7:0] goodStatus;
  assign goodStatus[7] = 1'b0;
  assign goodStatus[6] = linregCGood | loadSwitchAOn;
  assign goodStatus[5] = linregDGood | loadSwitchBOn;
  assign goodStatus[4] = buckAGood;
  assign goodStatus[3] = buckBGood;
  assign goodStatus[2] = buckCGood;
  assign goodStatus[1] = linregAGood;
  assign goodStatus[0] = linregBGood;

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  logic [7:0] key_ff;
  logic [7:0] pinCtrl_ff;
  logic [7:0] buckA_ff;
  pgr_key_st_t keySt_ff;
  pgr_key_st_t nxt_keySt;

  wire logic selKey = addrHit(req.addr, OFF_UNLOCK_KEY);
  wire logic selStatus = addrHit(req.addr, OFF_GOOD_STATUS);
  wire logic selPin = addrHit(req.addr, OFF_GOOD_PIN_CTRL);
  wire logic selBuck = addrHit(req.addr, OFF_BUCK_A_CTRL);
  wire logic hitKey = req.wr && selKey;
  wire logic unlocked = (key_ff == UNLOCK_CODE);
  wire logic wrPin = req.wr && selPin && unlocked;
  wire logic wrBuck = req.wr && selBuck && unlocked;
  wire logic otherWr = req.wr && !selKey;
  wire logic keyLive = (keySt_ff == KEY_LIVE);
  wire logic keyClear = otherWr || (txnDone && keyLive);

  always_comb begin
    case (keySt_ff)
      KEY_IDLE: nxt_keySt = hitKey ? KEY_WRITTEN : KEY_IDLE;
      KEY_WRITTEN: nxt_keySt = txnDone ? KEY_LIVE : KEY_WRITTEN;
      KEY_LIVE: nxt_keySt = (txnDone || otherWr) ? KEY_IDLE : KEY_LIVE;
      default: nxt_keySt = KEY_IDLE;
    endcase
    if (hitKey) begin
      nxt_keySt = KEY_WRITTEN;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      keySt_ff <= KEY_IDLE;
    end else if (ce) begin
      keySt_ff <= nxt_keySt;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      key_ff <= KEY_RESET;
    end else if (ce) begin
      if (hitKey) begin
        key_ff <= req.data;
      end else if (keyClear) begin
        key_ff <= KEY_RESET;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pinCtrl_ff <= PIN_CTRL_RESET;
    end else if (ce) begin
      if (wrPin) begin
        pinCtrl_ff <= req.data & PIN_CTRL_WMASK;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      buckA_ff <= BUCK_A_RESET_CODE & BUCK_A_WMASK;
    end else if (ce) begin
      if (wrBuck) begin
        buckA_ff <= req.data & BUCK_A_WMASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] rd_ff;
  wire logic [7:0] rdSel = selKey ? key_ff :
                           selStatus ? goodStatus :
                           selPin ? pinCtrl_ff :
                           selBuck ? buckA_ff : 8'h00;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rd_ff <= 8'h00;
    end else if (ce && req.rd) begin
      rd_ff <= rdSel;
    end
  end
  assign rdData = rd_ff;

  // ----------------------------------------------------------------
  // Buck A outputs
  // ----------------------------------------------------------------
  assign buckAExternalAdjust = buckA_ff[EXT_ADJ_BIT];
  assign buckAVoltageCode = buckA_ff[5:0];

  // ----------------------------------------------------------------
  // Power-good pin
  // ----------------------------------------------------------------
  wire logic maskA = pinCtrl_ff[MASK_A_BIT];
  wire logic maskB = pinCtrl_ff[MASK_B_BIT];
  wire logic [1:0] delayCode = pinCtrl_ff[1:0];
  wire logic allGood = (&goodStatus[6:2]) && (goodStatus[1] || maskA)
                       && (goodStatus[0] || maskB);
  wire logic [DLY_W-1:0] dlyTarget = delayCycles(delayCode);
  logic [DLY_W-1:0] dlyCnt_ff;
  logic pinHigh_ff;
  wire logic dlyDone = (dlyCnt_ff >= dlyTarget - DLY_W'(1));

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      dlyCnt_ff <= '0;
    end else if (ce) begin
      if (!allGood) begin
        dlyCnt_ff <= '0;
      end else if (!pinHigh_ff && !dlyDone) begin
        dlyCnt_ff <= dlyCnt_ff + DLY_W'(1);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pinHigh_ff <= 1'b0;
    end else if (ce) begin
      if (!allGood) begin
        pinHigh_ff <= 1'b0;
      end else if (dlyDone) begin
        pinHigh_ff <= 1'b1;
      end
    end
  end
  assign powerGoodOut = 1'b0;
  assign powerGoodOeN = pinHigh_ff;

endmodule

// ==== tb/pgr_regs_chk.sv ====
/* Checker for the pin, read and buck control paths.
   Bound to pgr_regs; sees its ports only. */
`timescale 1ns/100ps
module pgr_regs_chk
  import pgr_pkg::*;
#(
  parameter int DLY0_CYCLES = 10
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic ce,
  input wire pgr_req_t req,
  input wire logic [7:0] rdData,
  input wire logic [2:0] buckInReg,
  input wire logic [3:0] linregInReg,
  input wire logic loadSwitchA,
  input wire logic loadSwitchB,
  input wire logic powerGoodOut,
  input wire logic powerGoodOeN,
  input wire logic buckAExternalAdjust,
  input wire logic [5:0] buckAVoltageCode
);
  logic [31:0] hiCnt_ff;
  wire logic need = &buckInReg & (linregInReg[2] | loadSwitchA) & (linregInReg[3] | loadSwitchB);
  wire logic [31:0] nxt_hiCnt = need ? hiCnt_ff + 32'h0000_0001 : 32'h0000_0000;
  wire logic rdAt = ce & req.rd;
  wire logic bWr = ce & req.wr & (req.addr == OFF_BUCK_A_CTRL);
  always_ff @(posedge clock) begin
    hiCnt_ff <= sys_rst ? 32'h0000_0000 : nxt_hiCnt;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  property p_od; powerGoodOut == 1'h0; endproperty
  a_od: assert property (p_od) else $error("pin data not low");
  property p_drop; (!need)[*3] |=> !powerGoodOeN; endproperty
  a_drop: assert property (p_drop) else $error("pin stayed released");
  property p_rise; $rose(powerGoodOeN) |-> hiCnt_ff >= DLY0_CYCLES; endproperty
  a_rise: assert property (p_rise) else $error("pin released early");
  property p_hold; !bWr |=> $stable(buckAVoltageCode) && $stable(buckAExternalAdjust); endproperty
  a_hold: assert property (p_hold) else $error("buck control moved");
  property p_ext; bWr |=> buckAExternalAdjust == $past(req.data[7]) || $stable(buckAVoltageCode);
  endproperty
  a_ext: assert property (p_ext) else $error("adjust bit misplaced");
  property p_stat; rdAt && req.addr == OFF_GOOD_STATUS |=> rdData[7] == 1'h0; endproperty
  a_stat: assert property (p_stat) else $error("status bit 7 set");
  property p_pctl; rdAt && req.addr == OFF_GOOD_PIN_CTRL |=> rdData[7:4] == 4'h0; endproperty
  a_pctl: assert property (p_pctl) else $error("pin control top set");
  property p_buck; rdAt && req.addr == OFF_BUCK_A_CTRL
    |=> rdData == {buckAExternalAdjust, 1'h0, buckAVoltageCode}; endproperty
  a_buck: assert property (p_buck) else $error("buck readback wrong");
  c_rise: cover property ($rose(powerGoodOeN));
  c_buck: cover property (bWr);
  c_stat: cover property (rdAt && req.addr == OFF_GOOD_STATUS);
endmodule

// ==== tb/pgr_rail_model.sv ====
/* Regulator rail model driving the status inputs.
   Assumes the bench sets wanted rail states in status bit order. */
`timescale 1ns/100ps
module pgr_rail_model (
  input wire logic clock,
  input wire logic [6:0] rails,
  input wire logic [1:0] ls,
  output logic [2:0] buckInReg,
  output logic [3:0] linregInReg,
  output logic loadSwitchA,
  output logic loadSwitchB
);
  always_ff @(posedge clock) begin
    buckInReg <= {rails[2], rails[3], rails[4]};
    linregInReg <= {rails[5], rails[6], rails[0], rails[1]};
    {loadSwitchB, loadSwitchA} <= ls;
  end
endmodule

// ==== tb/test_pgr_regs.sv ====
/* Self-checking bench for pgr_regs.
   Assumes the rail model stands in for the regulators. */
`timescale 1ns/100ps
module test_pgr_regs;
  import pgr_pkg::*;
  localparam int DL [4] = '{10, 20, 30, 40};
  logic clock = 1'h0;
  logic sys_rst = 1'h1;
  logic ce = 1'h1;
  logic txnDone = 1'h0;
  pgr_req_t req = '0;
  logic [6:0] rails = 7'h00;
  logic [1:0] ls = 2'h0;
  logic [7:0] rdData, bad [4] = '{8'h00, 8'h7C, 8'h7E, 8'hFF};
  logic [2:0] buckInReg;
  logic [3:0] linregInReg;
  logic loadSwitchA, loadSwitchB, powerGoodOut, powerGoodOeN, buckAExternalAdjust;
  logic [5:0] buckAVoltageCode;
  int mismatches = 0;
  int checks = 0;
  int n;
  initial forever #2 clock = ~clock;
  pgr_rail_model rm (.clock, .rails, .ls, .buckInReg, .linregInReg, .loadSwitchA, .loadSwitchB);
  pgr_regs #(.DLY0_CYCLES(DL[0]), .DLY1_CYCLES(DL[1]), .DLY2_CYCLES(DL[2]), .DLY3_CYCLES(DL[3]))
    uut (.clock, .sys_rst, .ce, .req, .txnDone, .rdData, .buckInReg, .linregInReg, .loadSwitchA,
    .loadSwitchB, .powerGoodOut, .powerGoodOeN, .buckAExternalAdjust, .buckAVoltageCode);
  task automatic tick;
    @(posedge clock);
    #1;
  endtask
  task automatic cmp(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic isRd, input logic [7:0] a, input logic [7:0] d);
    req = '{~isRd, isRd, a, d};
    tick;
    req = '0;
    txnDone = 1'h1;
    tick;
    txnDone = 1'h0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    xfer(1'h1, a, 8'h00);
    cmp(rdData, exp);
  endtask
  task automatic unlock(input logic [7:0] a, input logic [7:0] d);
    xfer(1'h0, OFF_UNLOCK_KEY, UNLOCK_CODE);
    xfer(1'h0, a, d);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #20000;
    mismatches++;
    end_of_test;
  end
  initial begin
    repeat (6) tick;
    sys_rst = 1'h0;
    rd_chk(OFF_UNLOCK_KEY, 8'h00);
    rd_chk(OFF_GOOD_PIN_CTRL, 8'h0C);
    rd_chk(OFF_BUCK_A_CTRL, 8'h1E);
    rd_chk(8'h3F, 8'h00);
    xfer(1'h0, OFF_GOOD_STATUS, 8'hFF);
    rd_chk(OFF_GOOD_STATUS, 8'h00);
    foreach (bad[i]) begin
      xfer(1'h0, OFF_UNLOCK_KEY, bad[i]);
      xfer(1'h0, OFF_GOOD_PIN_CTRL, 8'h03);
      rd_chk(OFF_GOOD_PIN_CTRL, 8'h0C);
    end
    xfer(1'h0, OFF_UNLOCK_KEY, UNLOCK_CODE);
    rd_chk(OFF_UNLOCK_KEY, 8'h7D);
    rd_chk(OFF_UNLOCK_KEY, 8'h00);
    xfer(1'h0, OFF_GOOD_PIN_CTRL, 8'h03);
    rd_chk(OFF_GOOD_PIN_CTRL, 8'h0C);
    unlock(OFF_GOOD_PIN_CTRL, 8'hF3);
    xfer(1'h0, OFF_GOOD_PIN_CTRL, 8'h0C);
    rd_chk(OFF_GOOD_PIN_CTRL, 8'h03);
    unlock(OFF_BUCK_A_CTRL, 8'hFF);
    rd_chk(OFF_BUCK_A_CTRL, 8'hBF);
    cmp({buckAExternalAdjust, 1'h0, buckAVoltageCode}, 8'hBF);
    unlock(OFF_BUCK_A_CTRL, 8'h2A);
    rd_chk(OFF_BUCK_A_CTRL, 8'h2A);
    cmp({buckAExternalAdjust, 1'h0, buckAVoltageCode}, 8'h2A);
    for (int i = 0; i < 7; i++) begin
      rails = 7'(1 << i);
      repeat (4) tick;
      rd_chk(OFF_GOOD_STATUS, {1'h0, rails});
    end
    rails = 7'h00;
    ls = 2'h3;
    repeat (4) tick;
    rd_chk(OFF_GOOD_STATUS, 8'h60);
    ls = 2'h0;
    for (int c = 0; c < 4; c++) begin
      rails = 7'h00;
      unlock(OFF_GOOD_PIN_CTRL, 8'(8'h0C | c));
      rails = 7'h7C;
      n = 0;
      while (powerGoodOeN !== 1'h1 && n < 100) begin
        tick;
        n++;
      end
      cmp(8'(n >= DL[c] && n <= DL[c] + 6), 8'h01);
      cmp(8'(powerGoodOut), 8'h00);
      unlock(OFF_GOOD_PIN_CTRL, 8'((c % 2 == 1 ? 8'h04 : 8'h08) | c));
      repeat (2) tick;
      cmp(8'(powerGoodOeN), 8'h00);
    end
    end_of_test;
  end
endmodule
bind pgr_regs pgr_regs_chk #(.DLY0_CYCLES(DLY0_CYCLES)) chk (.clock, .sys_rst, .ce, .req, .rdData,
  .buckInReg, .linregInReg, .loadSwitchA, .loadSwitchB, .powerGoodOut, .powerGoodOeN,
  .buckAExternalAdjust, .buckAVoltageCode);
